// *** design/multi_channel_dma_controller.sv ***
// Channel controller, event queues and four transfer engines
//
// How it works
// R1: 64 event channels plus 8 quick channels
// R2: 256 parameter sets, any role
// R3: each set is eight 32-bit words
// R4: A-sync one dimension, AB-sync two per trigger
// R5: three dimensions, self-chaining finishes whole transfer
// R6: separate source and destination indexes
// R7: increment or constant addressing per side
// R8: link reloads active set automatically
// R9: completion chains to another channel
// R10: start by event, chain, or set write
// R11: quick channel fires on trigger word write
// R12: quick channel set selection programmable
// R13: parameter memory writable from configuration port
// R14: four queues, own engine, programmable priority
// R15: each queue holds 16 entries
// R16: 64-bit read and write ports
// R17: up to four requests in flight per engine
// R18: engine does 2-D, controller third dimension
// R19: completion and errors reported to software
// R20: watermark, threshold and error status visible
// R21: channel n fixed to event input n
// R22: events latched even while masked
// R23: each queue drains first-in first-out
//
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`include "multi_dma_cfg.svh"
module multi_channel_dma_controller #(
  parameter int NUM_SETS = 256,
  parameter int QDEPTH   = 16,
  parameter int INFLIGHT = 4,
  parameter int NUM_Q    = 4,
  parameter int NUM_QCH  = 8
) (
  input  wire logic                      sys_clk,
  input  wire logic                      reset_n,
  input  wire logic                      clk_en,
  input  wire logic [63:0]               event_in,
  input  wire logic [15:0]               reg_addr,
  input  wire logic [31:0]               reg_wdata,
  input  wire logic                      reg_we,
  input  wire logic                      reg_re,
  output logic [31:0]                    reg_rdata,
  output multi_dma_pkg::rd_cmd_t         rd_cmd [NUM_Q],
  input  wire logic [NUM_Q-1:0]          rd_valid,
  input  wire logic [NUM_Q-1:0]          rd_err,
  input  wire logic [63:0]               rd_data [NUM_Q],
  output multi_dma_pkg::wr_cmd_t         wr_cmd [NUM_Q],
  input  wire logic [NUM_Q-1:0]          wr_ack,
  output logic [3*NUM_Q-1:0]             eng_prio
);
  localparam int SW  = $clog2(NUM_SETS);
  localparam int QPW = $clog2(QDEPTH) + 1;

  function automatic logic [6:0] lowest64(input logic [63:0] v);
    lowest64 = '0;
    for (int i = 63; i >= 0; i--) begin
      if (v[i]) lowest64 = {1'b1, 6'(i)};
    end
  endfunction

  function automatic logic [31:0] step(input logic [31:0] a, input logic [15:0] idx,
                                       input logic hold);
    step = hold ? a : a + {{16{idx[15]}}, idx};
  endfunction

  logic [31:0]               pset_q [NUM_SETS*8];
  logic [63:0]               s1_q, s2_q, s3_q, lvl_q, evt_pulse;
  logic [63:0]               latch_q, mask_q;
  logic [NUM_QCH-1:0]        qpend_q;
  logic [71:0]               cmpl_q;
  logic [3*NUM_Q-1:0]        prio_q;
  logic [5*NUM_Q-1:0]        thresh_q, wmark_q;
  logic [NUM_Q-1:0]          rd_err_st_q, over_st_q;
  logic [10:0]               qmap_q [NUM_QCH];
  logic [31:0]               rdata_q;
  multi_dma_pkg::move_request_t qmem_q [NUM_Q][QDEPTH];
  logic [QPW-1:0]            wr_ptr_q [NUM_Q];
  logic [QPW-1:0]            iss_w [NUM_Q];
  logic [NUM_Q-1:0]          q_full;
  logic [NUM_Q-1:0]          done_w, err_w, chain_w;
  logic [6:0]                tcc_w [NUM_Q];
  logic [5:0]                chch_w [NUM_Q];
  logic [71:0]               cmpl_set;
  logic [63:0]               chain_set;

  // Register port decode
  logic pset_hit;
  assign pset_hit = reg_addr[15:13] == `PSET_REGION;

  // R21 fixed wiring; three-stage sampling, change taken when stages 2 and 3 agree
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      lvl_q <= '0;
    end else if (clk_en) begin
      s1_q  <= event_in;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      lvl_q <= (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
    end
  end
  assign evt_pulse = s2_q & s3_q & ~lvl_q;

  // Channel selection and descriptor update
  logic [6:0]   qsel, esel;
  logic         is_quick, sel_valid, go, last_row, final_x;
  logic [SW-1:0] sel_set;
  logic [31:0]  wd [8];
  logic [31:0]  lw [8];
  logic [31:0]  nw [8];
  logic [1:0]   tq;
  logic [15:0]  bcnt, ccnt, lk;
  multi_dma_pkg::move_request_t req;

  always_comb begin
    qsel      = lowest64({56'h0, qpend_q});
    esel      = lowest64(latch_q & mask_q);
    is_quick  = qsel[6];
    sel_valid = qsel[6] | esel[6];
    // R12 quick channel picks its own set
    sel_set   = is_quick ? qmap_q[qsel[2:0]][SW-1:0] : SW'(esel[5:0]);
    lk        = '0;
    for (int w = 0; w < 8; w++) begin
      wd[w] = pset_q[{sel_set, 3'(w)}];
    end
    lk = wd[5][31:16];
    for (int w = 0; w < 8; w++) begin
      lw[w] = pset_q[{lk[SW-1:0], 3'(w)}];
    end
    tq   = wd[0][`OPT_Q_LSB +: 2];
    bcnt = wd[2][31:16];
    ccnt = wd[7][15:0];
    // R14 queue chosen per set; a full queue holds the channel pending
    go   = sel_valid & ~reg_we & ~q_full[tq];
    req.src      = wd[1];
    req.dst      = wd[3];
    req.acnt     = wd[2][15:0];
    // R4 A-sync moves one array, AB-sync the whole frame
    req.bcnt     = wd[0][`OPT_ABSYNC] ? bcnt : 16'h0001;
    // R6 independent strides
    req.sbidx    = wd[4][15:0];
    req.dbidx    = wd[4][31:16];
    req.sconst   = wd[0][`OPT_SCONST];
    req.dconst   = wd[0][`OPT_DCONST];
    req.chain_ch = wd[0][`OPT_CHCH_LSB +: 6];
    req.tcc      = is_quick ? {4'h8, qsel[2:0]} : {1'b0, esel[5:0]};
    last_row = wd[0][`OPT_ABSYNC] | (bcnt <= 16'h0001);
    final_x  = last_row & (ccnt <= 16'h0001);
    // R5 intermediate chaining lets one event walk all three dimensions
    req.chain_en = final_x ? wd[0][`OPT_CHAIN] : wd[0][`OPT_ITCCHAIN];
    nw = wd;
    // R18 third dimension stepped here, not in the engine
    if (last_row) begin
      nw[1] = step(wd[1], wd[6][15:0], wd[0][`OPT_SCONST]);
      nw[3] = step(wd[3], wd[6][31:16], wd[0][`OPT_DCONST]);
      nw[2][31:16] = wd[5][15:0];
      nw[7][15:0]  = ccnt - 16'h0001;
    end else begin
      nw[1] = step(wd[1], wd[4][15:0], wd[0][`OPT_SCONST]);
      nw[3] = step(wd[3], wd[4][31:16], wd[0][`OPT_DCONST]);
      nw[2][31:16] = bcnt - 16'h0001;
    end
    // R8 link reload replaces the exhausted set
    if (final_x && lk != `LINK_NULL) begin
      nw = lw;
    end
  end

  // R2 R3 R13 parameter memory, eight words per set
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_SETS*8; i++) begin
        pset_q[i] <= '0;
      end
    end else if (clk_en) begin
      if (reg_we && pset_hit) begin
        pset_q[reg_addr[SW+4:2]] <= reg_wdata;
      end else if (go) begin
        for (int w = 0; w < 8; w++) begin
          pset_q[{sel_set, 3'(w)}] <= nw[w];
        end
      end
    end
  end

  // Latch: event, set write, chain; set wins over clear
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      latch_q <= '0;
    end else if (clk_en) begin
      // R22 capture ignores the mask
      // R10 three ways to start a channel
      latch_q <= (latch_q
                  & ~((go && !is_quick) ? (64'h1 << esel[5:0]) : 64'h0)
                  & ~((reg_we && reg_addr == `A_LATCH_LO) ? {32'h0, reg_wdata} : 64'h0)
                  & ~((reg_we && reg_addr == `A_LATCH_HI) ? {reg_wdata, 32'h0} : 64'h0))
                 | evt_pulse | chain_set
                 | ((reg_we && reg_addr == `A_SET_LO) ? {32'h0, reg_wdata} : 64'h0)
                 | ((reg_we && reg_addr == `A_SET_HI) ? {reg_wdata, 32'h0} : 64'h0);
    end
  end

  // R11 trigger word write fires the quick channel
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      qpend_q <= '0;
    end else if (clk_en) begin
      for (int q = 0; q < NUM_QCH; q++) begin
        if (reg_we && pset_hit && reg_addr[SW+4:2] == {qmap_q[q][SW-1:0], qmap_q[q][10:8]}) begin
          qpend_q[q] <= 1'b1;
        end else if (go && is_quick && qsel[2:0] == 3'(q)) begin
          qpend_q[q] <= 1'b0;
        end
      end
    end
  end

  // R1 R19 completion status; engine completion wins over software clear
  always_comb begin
    cmpl_set  = '0;
    chain_set = '0;
    for (int q = 0; q < NUM_Q; q++) begin
      if (done_w[q]) cmpl_set[tcc_w[q]] = 1'b1;
      // R9 completion chains onward
      if (done_w[q] && chain_w[q]) chain_set[chch_w[q]] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cmpl_q      <= '0;
      rd_err_st_q <= '0;
    end else if (clk_en) begin
      cmpl_q <= (cmpl_q
                 & ~((reg_we && reg_addr == `A_CMPL_LO) ? {40'h0, reg_wdata} : 72'h0)
                 & ~((reg_we && reg_addr == `A_CMPL_HI) ? {8'h0, reg_wdata, 32'h0} : 72'h0)
                 & ~((reg_we && reg_addr == `A_CMPL_Q) ? {reg_wdata[7:0], 64'h0} : 72'h0))
                | cmpl_set;
      rd_err_st_q <= (rd_err_st_q & ~((reg_we && reg_addr == `A_ERROR) ?
                      reg_wdata[NUM_Q-1:0] : '0)) | err_w;
    end
  end

  // Control registers
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      mask_q   <= '0;
      prio_q   <= `PRIO_RST;
      thresh_q <= `THRESH_RST;
      for (int q = 0; q < NUM_QCH; q++) begin
        qmap_q[q] <= {`QMAP_WORD_RST, 8'(64 + q)};
      end
    end else if (clk_en && reg_we) begin
      if (reg_addr == `A_MASK_LO) mask_q[31:0] <= reg_wdata;
      if (reg_addr == `A_MASK_HI) mask_q[63:32] <= reg_wdata;
      if (reg_addr == `A_PRIO) prio_q <= reg_wdata[3*NUM_Q-1:0];
      if (reg_addr == `A_THRESH) thresh_q <= reg_wdata[5*NUM_Q-1:0];
      for (int q = 0; q < NUM_QCH; q++) begin
        if (reg_addr == `A_QMAP0 + 16'(4 * q)) qmap_q[q] <= reg_wdata[10:0];
      end
    end
  end

  // R15 R23 queue write side
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int q = 0; q < NUM_Q; q++) begin
        wr_ptr_q[q] <= '0;
      end
    end else if (clk_en && go) begin
      qmem_q[tq][wr_ptr_q[tq][QPW-2:0]] <= req;
      wr_ptr_q[tq] <= wr_ptr_q[tq] + 1'b1;
    end
  end

  // R20 watermark of waiting entries and sticky over-threshold flag
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wmark_q   <= '0;
      over_st_q <= '0;
    end else if (clk_en) begin
      for (int q = 0; q < NUM_Q; q++) begin
        logic [QPW-1:0] wait_n;
        wait_n = wr_ptr_q[q] - iss_w[q];
        if (reg_we && reg_addr == `A_WMARK) begin
          wmark_q[5*q +: 5] <= '0;
        end else if (5'(wait_n) > wmark_q[5*q +: 5]) begin
          wmark_q[5*q +: 5] <= 5'(wait_n);
        end
        if (5'(wait_n) > thresh_q[5*q +: 5]) begin
          over_st_q[q] <= 1'b1;
        end else if (reg_we && reg_addr == `A_ERROR && reg_wdata[4+q]) begin
          over_st_q[q] <= 1'b0;
        end
      end
    end
  end

  // Read port, data in the following cycle only
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= '0;
    end else if (clk_en) begin
      rdata_q <= '0;
      if (reg_re) begin
        if (pset_hit) rdata_q <= pset_q[reg_addr[SW+4:2]];
        case (reg_addr)
          `A_LATCH_LO: rdata_q <= latch_q[31:0];
          `A_LATCH_HI: rdata_q <= latch_q[63:32];
          `A_MASK_LO:  rdata_q <= mask_q[31:0];
          `A_MASK_HI:  rdata_q <= mask_q[63:32];
          `A_CMPL_LO:  rdata_q <= cmpl_q[31:0];
          `A_CMPL_HI:  rdata_q <= cmpl_q[63:32];
          `A_CMPL_Q:   rdata_q <= {24'h0, cmpl_q[71:64]};
          `A_PRIO:     rdata_q <= 32'(prio_q);
          `A_THRESH:   rdata_q <= 32'(thresh_q);
          `A_WMARK:    rdata_q <= 32'(wmark_q);
          `A_ERROR:    rdata_q <= 32'({over_st_q, rd_err_st_q});
          default: begin
            for (int q = 0; q < NUM_QCH; q++) begin
              if (reg_addr == `A_QMAP0 + 16'(4 * q)) rdata_q <= {21'h0, qmap_q[q]};
            end
          end
        endcase
      end
    end
  end
  assign reg_rdata = rdata_q;
  assign eng_prio  = prio_q;

  // Transfer engines, one per queue
  for (genvar g = 0; g < NUM_Q; g++) begin : g_eng
    logic [QPW-1:0]              iss_q, hd_q;
    multi_dma_pkg::eng_state_t   st_q;
    multi_dma_pkg::move_request_t cur;
    multi_dma_pkg::rd_cmd_t      rd_q;
    multi_dma_pkg::wr_cmd_t      wr_q;
    logic [15:0]                 a_q, b_q;
    logic [31:0]                 src_q, dst_q, rsrc_q, rdst_q;
    logic                        done_q, err_q;

    assign cur       = qmem_q[g][hd_q[QPW-2:0]];
    assign q_full[g] = (wr_ptr_q[g] - hd_q) == QPW'(QDEPTH);
    assign iss_w[g]  = iss_q;
    assign done_w[g] = done_q;
    assign err_w[g]  = err_q;
    assign tcc_w[g]  = cur.tcc;
    assign chch_w[g] = cur.chain_ch;
    assign chain_w[g] = cur.chain_en;
    assign rd_cmd[g] = rd_q;
    assign wr_cmd[g] = wr_q;

    // R17 at most four taken from the queue and not yet retired
    always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
        iss_q <= '0;
      end else if (clk_en) begin
        if (iss_q != wr_ptr_q[g] && (iss_q - hd_q) < QPW'(INFLIGHT)) begin
          iss_q <= iss_q + 1'b1;
        end
      end
    end

    // R16 R18 beat loop over A, then B with row strides
    // Head entry stays put until done so its fields can be reported
    always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
        st_q   <= multi_dma_pkg::ENG_IDLE;
        hd_q   <= '0;
        rd_q   <= '0;
        wr_q   <= '0;
        a_q    <= '0;
        b_q    <= '0;
        src_q  <= '0;
        dst_q  <= '0;
        rsrc_q <= '0;
        rdst_q <= '0;
        done_q <= 1'b0;
        err_q  <= 1'b0;
      end else if (clk_en) begin
        done_q <= 1'b0;
        err_q  <= 1'b0;
        if (done_q) hd_q <= hd_q + 1'b1;
        case (st_q)
          multi_dma_pkg::ENG_IDLE: begin
            // R23 oldest issued entry first
            if (hd_q != iss_q && !done_q) begin
              if (cur.acnt == 16'h0 || cur.bcnt == 16'h0) begin
                done_q <= 1'b1;
              end else begin
                a_q     <= cur.acnt;
                b_q     <= cur.bcnt;
                src_q   <= cur.src;
                dst_q   <= cur.dst;
                rsrc_q  <= cur.src;
                rdst_q  <= cur.dst;
                rd_q    <= '{req: 1'b1, addr: cur.src};
                st_q    <= multi_dma_pkg::ENG_READ;
              end
            end
          end
          multi_dma_pkg::ENG_READ: begin
            if (rd_valid[g]) begin
              rd_q.req <= 1'b0;
              // R19 read error aborts and is flagged
              if (rd_err[g]) begin
                err_q  <= 1'b1;
                done_q <= 1'b1;
                st_q   <= multi_dma_pkg::ENG_IDLE;
              end else begin
                wr_q <= '{req: 1'b1, addr: dst_q, data: rd_data[g]};
                st_q <= multi_dma_pkg::ENG_WRITE;
              end
            end
          end
          multi_dma_pkg::ENG_WRITE: begin
            if (wr_ack[g]) begin
              wr_q.req <= 1'b0;
              // R7 constant side keeps its address
              if (a_q > 16'h0001) begin
                a_q      <= a_q - 16'h0001;
                src_q    <= step(src_q, `BEAT_STEP, cur.sconst);
                dst_q    <= step(dst_q, `BEAT_STEP, cur.dconst);
                rd_q     <= '{req: 1'b1, addr: step(src_q, `BEAT_STEP, cur.sconst)};
                st_q     <= multi_dma_pkg::ENG_READ;
              end else if (b_q > 16'h0001) begin
                b_q      <= b_q - 16'h0001;
                a_q      <= cur.acnt;
                rsrc_q   <= step(rsrc_q, cur.sbidx, cur.sconst);
                rdst_q   <= step(rdst_q, cur.dbidx, cur.dconst);
                src_q    <= step(rsrc_q, cur.sbidx, cur.sconst);
                dst_q    <= step(rdst_q, cur.dbidx, cur.dconst);
                rd_q     <= '{req: 1'b1, addr: step(rsrc_q, cur.sbidx, cur.sconst)};
                st_q     <= multi_dma_pkg::ENG_READ;
              end else begin
                done_q <= 1'b1;
                st_q   <= multi_dma_pkg::ENG_IDLE;
              end
            end
          end
          default: st_q <= multi_dma_pkg::ENG_IDLE;
        endcase
      end
    end
  end : g_eng
endmodule // multi_channel_dma_controller

// *** design/multi_dma_cfg.svh ***
// Register offsets, descriptor fields, reset values for the DMA controller
`ifndef MULTI_DMA_CFG_SVH
`define MULTI_DMA_CFG_SVH
`define A_LATCH_LO   16'h1000
`define A_LATCH_HI   16'h1004
`define A_SET_LO     16'h1008
`define A_SET_HI     16'h100c
`define A_MASK_LO    16'h1010
`define A_MASK_HI    16'h1014
`define A_CMPL_LO    16'h1018
`define A_CMPL_HI    16'h101c
`define A_CMPL_Q     16'h1020
`define A_PRIO       16'h1024
`define A_THRESH     16'h1028
`define A_WMARK      16'h102c
`define A_ERROR      16'h1030
`define A_QMAP0      16'h1040
`define PSET_REGION  3'h2
`define OPT_SCONST   0
`define OPT_DCONST   1
`define OPT_ABSYNC   2
`define OPT_CHAIN    3
`define OPT_ITCCHAIN 4
`define OPT_CHCH_LSB 8
`define OPT_Q_LSB    16
`define LINK_NULL    16'hffff
`define BEAT_STEP    16'h0008
`define PRIO_RST     12'h688
`define THRESH_RST   20'h84210
`define QMAP_WORD_RST 3'h7
`endif

// *** design/multi_dma_pkg.sv ***
// Types shared by the DMA controller and its surroundings
package multi_dma_pkg;
  typedef struct packed {
    logic [31:0] src;
    logic [31:0] dst;
    logic [15:0] acnt;
    logic [15:0] bcnt;
    logic [15:0] sbidx;
    logic [15:0] dbidx;
    logic        sconst;
    logic        dconst;
    logic        chain_en;
    logic [5:0]  chain_ch;
    logic [6:0]  tcc;
  } move_request_t;
  typedef struct packed {
    logic        req;
    logic [31:0] addr;
  } rd_cmd_t;
  typedef struct packed {
    logic        req;
    logic [31:0] addr;
    logic [63:0] data;
  } wr_cmd_t;
  typedef enum logic [1:0] {ENG_IDLE, ENG_READ, ENG_WRITE} eng_state_t;
endpackage

// *** bench/multi_dma_monitor.sv ***
// Port checker for the DMA controller
`timescale 1ns/1ps
`include "multi_dma_cfg.svh"
module multi_dma_monitor #(
  parameter int NUM_Q = 4
) (
  input wire logic               sys_clk,
  input wire logic               reset_n,
  input wire logic [15:0]        reg_addr,
  input wire logic [31:0]        reg_wdata,
  input wire logic               reg_we,
  input wire logic               reg_re,
  input wire logic [31:0]        reg_rdata,
  input multi_dma_pkg::rd_cmd_t  rd_cmd [NUM_Q],
  input wire logic [NUM_Q-1:0]   rd_valid,
  input wire logic [NUM_Q-1:0]   rd_err,
  input wire logic [63:0]        rd_data [NUM_Q],
  input multi_dma_pkg::wr_cmd_t  wr_cmd [NUM_Q],
  input wire logic [NUM_Q-1:0]   wr_ack,
  input wire logic [3*NUM_Q-1:0] eng_prio
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  logic pw;
  logic rok;
  assign pw = reg_we && reg_addr == `A_PRIO;
  // Engine 0 only, bar the slow cover on engine 3: the others share its logic
  assign rok = rd_cmd[0].req && rd_valid[0];
  property p_prio_load; pw |=> eng_prio == $past(reg_wdata[3*NUM_Q-1:0]); endproperty
  a_prio_load: assert property (p_prio_load) else $error("prio not loaded");
  property p_prio_hold; !pw |=> $stable(eng_prio); endproperty
  a_prio_hold: assert property (p_prio_hold) else $error("prio moved");
  property p_rdata; !$past(reg_re) |-> reg_rdata == 32'h0; endproperty
  a_rdata: assert property (p_rdata) else $error("stray read data");
  property p_rd_hold;
    rd_cmd[0].req && !rd_valid[0] |=> rd_cmd[0].req && $stable(rd_cmd[0].addr);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read req dropped");
  property p_wr_hold;
    wr_cmd[0].req && !wr_ack[0] |=> wr_cmd[0].req && $stable(wr_cmd[0].data);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write req dropped");
  property p_wr_data;
    rok && !rd_err[0] |=> wr_cmd[0].req && wr_cmd[0].data == $past(rd_data[0]);
  endproperty
  a_wr_data: assert property (p_wr_data) else $error("write data differs");
  property p_err_abort; rok && rd_err[0] |=> !wr_cmd[0].req; endproperty
  a_err_abort: assert property (p_err_abort) else $error("write after error");
  property p_one_beat; !(rd_cmd[0].req && wr_cmd[0].req); endproperty
  a_one_beat: assert property (p_one_beat) else $error("read and write together");
  c_err: cover property (rok && rd_err[0]);
  c_slow: cover property (wr_cmd[3].req && wr_ack[3]);
  c_prio: cover property (pw);
endmodule // multi_dma_monitor

bind multi_channel_dma_controller multi_dma_monitor #(.NUM_Q(NUM_Q)) u_mon (
  .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .rd_cmd(rd_cmd),
  .rd_valid(rd_valid), .rd_err(rd_err), .rd_data(rd_data), .wr_cmd(wr_cmd),
  .wr_ack(wr_ack), .eng_prio(eng_prio));

// *** bench/dma_mem_model.sv ***
// Memory model answering the transfer engines
`timescale 1ns/1ps
module dma_mem_model #(
  parameter int NUM_Q = 4
) (
  input wire logic              sys_clk,
  input wire logic              reset_n,
  input wire logic [31:0]       err_addr,
  input multi_dma_pkg::rd_cmd_t rd_cmd [NUM_Q],
  output logic [NUM_Q-1:0]      rd_valid,
  output logic [NUM_Q-1:0]      rd_err,
  output logic [63:0]           rd_data [NUM_Q],
  input multi_dma_pkg::wr_cmd_t wr_cmd [NUM_Q],
  output logic [NUM_Q-1:0]      wr_ack
);
  logic [63:0] wmem [logic [31:0]];
  int          n_wr;
  int          wait_q [NUM_Q];
  // Engine q waits q cycles, so prompt and slow answers both occur
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_valid <= '0;
      rd_err <= '0;
      wr_ack <= '0;
      n_wr = 0;
      for (int q = 0; q < NUM_Q; q++) begin
        rd_data[q] <= '0;
        wait_q[q] = 0;
      end
    end else begin
      for (int q = 0; q < NUM_Q; q++) begin
        rd_valid[q] <= 1'b0;
        rd_err[q] <= 1'b0;
        wr_ack[q] <= 1'b0;
        if (rd_valid[q] || wr_ack[q] || !(rd_cmd[q].req || wr_cmd[q].req)) begin
          // Idle bus shows inverted data, never a stale copy
          rd_data[q] <= ~rd_data[q];
          wait_q[q] = 0;
        end else if (wait_q[q] < q) begin
          rd_data[q] <= ~rd_data[q];
          wait_q[q]++;
        end else if (rd_cmd[q].req) begin
          rd_valid[q] <= 1'b1;
          rd_err[q] <= rd_cmd[q].addr == err_addr;
          rd_data[q] <= {~rd_cmd[q].addr, rd_cmd[q].addr};
        end else begin
          rd_data[q] <= ~rd_data[q];
          wmem[wr_cmd[q].addr] = wr_cmd[q].data;
          n_wr++;
          wr_ack[q] <= 1'b1;
        end
      end
    end
  end
endmodule // dma_mem_model

// *** bench/test_multi_channel_dma_controller.sv ***
// Self-checking bench for the DMA controller
`timescale 1ns/1ps
`include "multi_dma_cfg.svh"
module test_multi_channel_dma_controller;
  logic                   sys_clk = 1'b0;
  logic                   reset_n = 1'b0;
  logic [63:0]            event_in = '0;
  logic [15:0]            reg_addr = '0;
  logic [31:0]            reg_wdata = '0;
  logic                   reg_we = 1'b0;
  logic                   reg_re = 1'b0;
  logic [31:0]            reg_rdata;
  logic [31:0]            d;
  multi_dma_pkg::rd_cmd_t rd_cmd [4];
  multi_dma_pkg::wr_cmd_t wr_cmd [4];
  logic [63:0]            rd_data [4];
  logic [3:0]             rd_valid;
  logic [3:0]             rd_err;
  logic [3:0]             wr_ack;
  logic [11:0]            eng_prio;
  int                     n_fail = 0;
  int                     samples_checked = 0;
  int                     cycles = 0;
  always #20 sys_clk = ~sys_clk;
  multi_channel_dma_controller dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .clk_en(1'b1), .event_in(event_in),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata), .rd_cmd(rd_cmd), .rd_valid(rd_valid), .rd_err(rd_err),
    .rd_data(rd_data), .wr_cmd(wr_cmd), .wr_ack(wr_ack), .eng_prio(eng_prio));
  dma_mem_model u_mem (
    .sys_clk(sys_clk), .reset_n(reset_n), .err_addr(32'h0000_0c00), .rd_cmd(rd_cmd),
    .rd_valid(rd_valid), .rd_err(rd_err), .rd_data(rd_data), .wr_cmd(wr_cmd),
    .wr_ack(wr_ack));
  task automatic final_report();
    $display("checks %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_we <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge sys_clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_re <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic rchk(input logic [15:0] a, input logic [31:0] exp);
    rd(a);
    chk(d, exp);
  endtask
  task automatic put_set(input int s, input logic [31:0] w [8]);
    for (int i = 0; i < 8; i++) begin
      wr(16'h4000 + 16'(s * 32 + i * 4), w[i]);
    end
  endtask
  // Polls a status bit a bounded number of times
  task automatic wait_bit(input logic [15:0] a, input int b);
    rd(a);
    for (int i = 0; i < 100 && d[b] !== 1'b1; i++) begin
      rd(a);
    end
    chk(d[b], 1'b1);
  endtask
  // Fixed window: proving no extra beats needs a wait
  task automatic settle(input int n);
    repeat (60) @(posedge sys_clk);
    chk(u_mem.n_wr, n);
  endtask
  function automatic logic [63:0] bv(input logic [31:0] a);
    return {~a, a};
  endfunction
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      final_report();
    end
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    rchk(`A_PRIO, 32'(`PRIO_RST));
    rchk(`A_THRESH, 32'(`THRESH_RST));
    rchk(`A_QMAP0, {21'h0, `QMAP_WORD_RST, 8'h40});
    rchk(16'h1100, 32'h0);
    wr(`A_PRIO, 32'h0000_0123);
    rchk(`A_PRIO, 32'h0000_0123);
    chk(eng_prio, 12'h123);
    put_set(5, '{32'h0001_0004, 32'h100, 32'h0002_0002, 32'h200, 32'h0020_0010,
                 32'hffff_0002, 32'h0, 32'h1});
    @(posedge sys_clk);
    event_in[5] <= 1'b1;
    repeat (8) @(posedge sys_clk);
    event_in[5] <= 1'b0;
    rchk(`A_LATCH_LO, 32'h0000_0020);
    settle(0);
    wr(`A_MASK_LO, 32'h0000_07e0);
    wait_bit(`A_CMPL_LO, 5);
    for (int r = 0; r < 2; r++) begin
      for (int b = 0; b < 2; b++) begin
        chk(u_mem.wmem[32'h200 + r * 32 + b * 8], bv(32'h100 + r * 16 + b * 8));
      end
    end
    put_set(6, '{32'h0002_0002, 32'h400, 32'h0002_0002, 32'h300, 32'h0000_0010,
                 32'hffff_0002, 32'h0, 32'h1});
    wr(`A_SET_LO, 32'h0000_0040);
    settle(6);
    chk(u_mem.wmem[32'h300], bv(32'h408));
    wr(`A_SET_LO, 32'h0000_0040);
    settle(8);
    chk(u_mem.wmem[32'h300], bv(32'h418));
    wr(`A_QMAP0, 32'h0000_0764);
    put_set(100, '{32'h0003_0004, 32'h500, 32'h0001_0001, 32'h600, 32'h0,
                   32'hffff_0001, 32'h0, 32'h1});
    wait_bit(`A_CMPL_Q, 0);
    chk(u_mem.wmem[32'h600], bv(32'h500));
    put_set(8, '{32'h4, 32'h900, 32'h0001_0001, 32'ha00, 32'h0, 32'hffff_0001, 32'h0, 32'h1});
    put_set(7, '{32'h80c, 32'h700, 32'h0001_0001, 32'h800, 32'h0, 32'hffff_0001, 32'h0, 32'h1});
    wr(`A_SET_LO, 32'h0000_0080);
    wait_bit(`A_CMPL_LO, 8);
    chk(u_mem.wmem[32'ha00], bv(32'h900));
    put_set(200, '{32'h4, 32'hb00, 32'h0001_0001, 32'hb80, 32'h0, 32'hffff_0001, 32'h0, 32'h1});
    put_set(9, '{32'h4, 32'he00, 32'h0001_0001, 32'hf00, 32'h0, 32'h00c8_0001, 32'h0, 32'h1});
    wr(`A_SET_LO, 32'h0000_0200);
    wait_bit(`A_CMPL_LO, 9);
    rchk(16'h4124, 32'h0000_0b00);
    put_set(10, '{32'h4, 32'hc00, 32'h0001_0001, 32'hd00, 32'h0, 32'hffff_0001, 32'h0, 32'h1});
    wr(`A_SET_LO, 32'h0000_0400);
    wait_bit(`A_CMPL_LO, 10);
    wait_bit(`A_ERROR, 0);
    chk(u_mem.wmem.exists(32'hd00), 0);
    wr(`A_CMPL_LO, 32'h0000_07e0);
    rchk(`A_CMPL_LO, 32'h0);
    final_report();
  end
endmodule // test_multi_channel_dma_controller
